// >>> pkg/ppgd_regs.vh
// Timing and mode constants for the push-pull gate drive sequencer
`ifndef PPGD_REGS_VH
`define PPGD_REGS_VH
// Clock period in picoseconds (200 MHz)
`define PPGD_CLK_PS 5000
// External clock fail-safe window in microseconds
`define PPGD_EXT_FAIL_MIN_US 10
`define PPGD_EXT_FAIL_MAX_US 25
// Chosen timeout inside the window, microseconds
`define PPGD_EXT_TIMEOUT_US 16
// Break-before-make gap in nanoseconds per variant
`define PPGD_BBM_LF_NS 128
`define PPGD_BBM_HF_NS 90
// Overcurrent persistence and forced-off period in milliseconds
`define PPGD_OC_MS 10
`define PPGD_OFF_MS 10
// Soft-start ramp in milliseconds
`define PPGD_SS_MS 5
// Protection state codes
`define PPGD_ST_RUN 2'h0
`define PPGD_ST_OFF 2'h1
`define PPGD_ST_SS 2'h2
`endif

// >>> core/ppgd_clk_mon.v
// External clock validity monitor with timeout
`timescale 1ns/1ps
`include "ppgd_regs.vh"
module ppgd_clk_mon #(
  parameter TIMEOUT_CYC = (`PPGD_EXT_TIMEOUT_US * 1000000) / `PPGD_CLK_PS
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ext_rise,
  output reg o_valid
);
  reg [15:0] cnt_r;
  // =====================================================
  // Cycle count since last external rising edge
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
      o_valid <= 1'b0;
    end else if (i_ext_rise) begin
      cnt_r <= 16'h0000;
      o_valid <= 1'b1;
    end else if (cnt_r >= TIMEOUT_CYC[15:0] - 16'h0001) begin
      // Timeout lands inside the fallback window
      o_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule

// >>> core/ppgd_seq.v
// Push-pull gate drive sequencer top level
// Operation
// - Fall back to internal clock after 10..25 us of bad external clock
// - Divide selected clock by two into complementary 50% phase signals
// - Insert dead time between phase highs: 128 ns low, 90 ns high freq
// - The two gates alternate and are never high together
// - Both gates low for the dead time before either may rise
// - External mode toggles divider on clock rise, spread spectrum off
// - Enable low or supply lockout holds both drains off, high impedance
// - Overcurrent over 10 ms forces off 10 ms, then soft start
`timescale 1ns/1ps
`include "ppgd_regs.vh"
module ppgd_seq #(
  parameter HF_VARIANT = 0,
  parameter OSC_HALF_CYC = 625,
  // Counted via nanoseconds so the product stays inside 32 bits
  parameter OC_CYC = (`PPGD_OC_MS * 1000000) / (`PPGD_CLK_PS / 1000),
  parameter OFF_CYC = (`PPGD_OFF_MS * 1000000) / (`PPGD_CLK_PS / 1000),
  parameter SS_CYC = (`PPGD_SS_MS * 1000000) / (`PPGD_CLK_PS / 1000)
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_enable,
  input wire i_supply_lockout,
  input wire i_ext_clk,
  input wire i_ext_mode,
  input wire i_current_limit_state,
  output reg o_phase_a,
  output reg o_phase_b,
  output reg o_gate_a,
  output reg o_gate_b,
  output reg o_drain_out_a_oe,
  output reg o_drain_out_b_oe,
  output reg o_ext_active,
  output reg o_spread_spectrum_modulation,
  output reg o_forced_off_state,
  output reg o_soft_start
);
  // Least time rounds up to whole cycles
  localparam BBM_NS = HF_VARIANT ? `PPGD_BBM_HF_NS : `PPGD_BBM_LF_NS;
  localparam BBM_CYC = (BBM_NS * 1000 + `PPGD_CLK_PS - 1) / `PPGD_CLK_PS;
  localparam [1:0] ST_RUN = `PPGD_ST_RUN;
  localparam [1:0] ST_OFF = `PPGD_ST_OFF;
  localparam [1:0] ST_SS = `PPGD_ST_SS;

  reg ext_d_r;
  reg [15:0] osc_cnt_r;
  reg osc_tick_r;
  reg [7:0] bbm_cnt_r;
  reg last_a_r;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [31:0] tmr_r;
  reg [31:0] tmr_nxt;
  reg [31:0] oc_cnt_r;
  wire ext_rise;
  wire ext_valid;
  wire sel_ext;
  wire div_tick;
  wire halt;

  // =====================================================
  // External clock edge and validity
  assign ext_rise = i_ext_clk & ~ext_d_r;

  ppgd_clk_mon u_mon (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ext_rise(ext_rise),
    .o_valid(ext_valid)
  );

  // External source only while requested and judged valid
  assign sel_ext = i_ext_mode & ext_valid;
  // Divider steps on external rise or internal oscillator tick
  assign div_tick = sel_ext ? ext_rise : osc_tick_r;
  // Any off condition parks the gates
  assign halt = ~i_enable | i_supply_lockout | (st_r == ST_OFF);

  // =====================================================
  // Edge history and internal oscillator model
  always @(posedge i_clk) begin
    if (i_rst) begin
      ext_d_r <= 1'b0;
      osc_cnt_r <= 16'h0000;
      osc_tick_r <= 1'b0;
    end else begin
      ext_d_r <= i_ext_clk;
      if (osc_cnt_r >= OSC_HALF_CYC[15:0] - 16'h0001) begin
        osc_cnt_r <= 16'h0000;
        osc_tick_r <= 1'b1;
      end else begin
        osc_cnt_r <= osc_cnt_r + 16'h0001;
        osc_tick_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // Divide-by-two into complementary phases
  always @(posedge i_clk) begin
    if (i_rst | halt) begin
      o_phase_a <= 1'b0;
      o_phase_b <= 1'b1;
    end else if (div_tick) begin
      o_phase_a <= ~o_phase_a;
      o_phase_b <= o_phase_a;
    end
  end

  // =====================================================
  // Break-before-make: gates drop one cycle after the phase edge, rise after gap
  // Counter restarts on each phase change so both stay low the full gap
  always @(posedge i_clk) begin
    if (i_rst | halt) begin
      o_gate_a <= 1'b0;
      o_gate_b <= 1'b0;
      bbm_cnt_r <= 8'h00;
      last_a_r <= 1'b0;
    end else begin
      last_a_r <= o_phase_a;
      if (last_a_r != o_phase_a) begin
        o_gate_a <= 1'b0;
        o_gate_b <= 1'b0;
        bbm_cnt_r <= 8'h00;
      end else if (bbm_cnt_r < BBM_CYC[7:0] - 8'h01) begin
        bbm_cnt_r <= bbm_cnt_r + 8'h01;
      end else begin
        // Phases are exact complements, so only one gate rises
        o_gate_a <= o_phase_a;
        o_gate_b <= ~o_phase_a;
      end
    end
  end

  // =====================================================
  // Overcurrent protection sequence
  always @* begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    case (st_r)
      ST_RUN: begin
        if (oc_cnt_r >= OC_CYC - 1) begin
          st_nxt = ST_OFF;
          tmr_nxt = 32'h00000000;
        end
      end
      ST_OFF: begin
        if (tmr_r >= OFF_CYC - 1) begin
          st_nxt = ST_SS;
          tmr_nxt = 32'h00000000;
        end else begin
          tmr_nxt = tmr_r + 32'h00000001;
        end
      end
      ST_SS: begin
        if (tmr_r >= SS_CYC - 1) begin
          st_nxt = ST_RUN;
          tmr_nxt = 32'h00000000;
        end else begin
          tmr_nxt = tmr_r + 32'h00000001;
        end
      end
      default: begin
        st_nxt = ST_RUN;
        tmr_nxt = 32'h00000000;
      end
    endcase
  end

  // State, protection timer and persistence counter
  always @(posedge i_clk) begin
    if (i_rst | ~i_enable | i_supply_lockout) begin
      st_r <= ST_RUN;
      tmr_r <= 32'h00000000;
      oc_cnt_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      if (st_r == ST_RUN && i_current_limit_state)
        oc_cnt_r <= oc_cnt_r + 32'h00000001;
      else
        oc_cnt_r <= 32'h00000000;
    end
  end

  // =====================================================
  // Drain enables and status flags, all registered
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_drain_out_a_oe <= 1'b0;
      o_drain_out_b_oe <= 1'b0;
      o_ext_active <= 1'b0;
      o_spread_spectrum_modulation <= 1'b0;
      o_forced_off_state <= 1'b0;
      o_soft_start <= 1'b0;
    end else begin
      o_drain_out_a_oe <= ~halt;
      o_drain_out_b_oe <= ~halt;
      o_ext_active <= sel_ext;
      // Spreading only on the internal oscillator
      o_spread_spectrum_modulation <= ~sel_ext & ~halt;
      o_forced_off_state <= (st_r == ST_OFF);
      o_soft_start <= (st_r == ST_SS);
    end
  end
endmodule

// >>> sim/ppgd_ext_src.sv
// External sync clock source, idle low between bursts
`timescale 1ns/1ps
module ppgd_ext_src (
  input wire i_run,
  output logic o_clk = 1'b0
);
  // Odd half period keeps it unrelated to the core clock
  always begin
    wait (i_run);
    #251 o_clk = 1'b1;
    #251 o_clk = 1'b0;
  end
endmodule

// >>> sim/ppgd_seq_properties.sv
// Checker bound to the gate drive sequencer
`timescale 1ns/1ps
// Least both-low run in cycles: 26 for the low-frequency gap, 18 for high
module ppgd_seq_properties #(
  parameter GAP_MIN = 26
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_enable,
  input wire i_supply_lockout,
  input wire i_ext_clk,
  input wire o_phase_a,
  input wire o_phase_b,
  input wire o_gate_a,
  input wire o_gate_b,
  input wire o_ext_active,
  input wire o_drain_out_a_oe,
  input wire o_drain_out_b_oe,
  input wire o_soft_start,
  input wire o_spread_spectrum_modulation,
  input wire o_forced_off_state
);
  reg [7:0] low_n;
  // Both-low run length; saturates so long idles never wrap
  always @(posedge i_clk)
    if (i_rst || o_gate_a || o_gate_b) low_n <= 8'h00;
    else if (low_n != 8'hFF) low_n <= low_n + 8'h01;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence ext_rise;
    o_ext_active && i_ext_clk && !$past(i_ext_clk);
  endsequence
  chk_gate_overlap: assert property (!(o_gate_a && o_gate_b))
    else $error("gates overlap");
  chk_phase_pair: assert property (o_phase_a != o_phase_b)
    else $error("phases equal");
  chk_dead_gap: assert property
    ($rose(o_gate_a) || $rose(o_gate_b) |-> low_n >= GAP_MIN)
    else $error("gap short");
  chk_drain_off: assert property
    (!i_enable || i_supply_lockout |=>
      !o_drain_out_a_oe && !o_drain_out_b_oe) else $error("drain on");
  chk_forced_off: assert property
    (o_forced_off_state |-> !(o_drain_out_a_oe || o_gate_a || o_gate_b))
    else $error("on while off");
  chk_soft_follows: assert property
    ($fell(o_forced_off_state) && $past(i_enable) &&
      !$past(i_supply_lockout) |-> o_soft_start) else $error("no ramp");
  chk_no_spread: assert property
    (o_ext_active |-> !o_spread_spectrum_modulation) else $error("spread");
  chk_ext_toggle: assert property
    (ext_rise |-> ##[1:3] $changed(o_phase_a)) else $error("no toggle");
endmodule
bind ppgd_seq ppgd_seq_properties i_ppgd_seq_properties (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_enable(i_enable),
  .i_supply_lockout(i_supply_lockout),
  .i_ext_clk(i_ext_clk),
  .o_phase_a(o_phase_a),
  .o_phase_b(o_phase_b),
  .o_gate_a(o_gate_a),
  .o_gate_b(o_gate_b),
  .o_ext_active(o_ext_active),
  .o_drain_out_a_oe(o_drain_out_a_oe),
  .o_drain_out_b_oe(o_drain_out_b_oe),
  .o_soft_start(o_soft_start),
  .o_spread_spectrum_modulation(o_spread_spectrum_modulation),
  .o_forced_off_state(o_forced_off_state)
);

// >>> sim/ppgd_seq_bench.sv
// Bench for the gate drive sequencer
`timescale 1ns/1ps
module ppgd_seq_bench;
  logic i_clk = 0, i_rst = 1, i_enable = 0, i_supply_lockout = 0;
  logic i_ext_mode = 0, i_current_limit_state = 0, run = 0, p;
  wire i_ext_clk, o_phase_a, o_phase_b, o_gate_a, o_gate_b, o_ext_active;
  wire o_drain_out_a_oe, o_drain_out_b_oe, o_spread_spectrum_modulation;
  wire o_forced_off_state, o_soft_start;
  int n_errors = 0, compares = 0, n;
  ppgd_ext_src i_ppgd_ext_src (.i_run(run), .o_clk(i_ext_clk));
  // Short protection counts keep the run brief
  ppgd_seq #(.OSC_HALF_CYC(60), .OC_CYC(50), .OFF_CYC(50), .SS_CYC(50))
    i_ppgd_seq (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_enable(i_enable),
      .i_supply_lockout(i_supply_lockout),
      .i_ext_clk(i_ext_clk),
      .i_ext_mode(i_ext_mode),
      .i_current_limit_state(i_current_limit_state),
      .o_phase_a(o_phase_a),
      .o_phase_b(o_phase_b),
      .o_gate_a(o_gate_a),
      .o_gate_b(o_gate_b),
      .o_drain_out_a_oe(o_drain_out_a_oe),
      .o_drain_out_b_oe(o_drain_out_b_oe),
      .o_ext_active(o_ext_active),
      .o_spread_spectrum_modulation(o_spread_spectrum_modulation),
      .o_forced_off_state(o_forced_off_state),
      .o_soft_start(o_soft_start)
    );
  initial forever #2.5 i_clk = ~i_clk;
  task automatic ck(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %0t: got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Internal clock: tick rate, dead time, gate of the high phase
  task automatic t_int;
    n = 0;
    p = o_phase_a;
    repeat (600) begin
      cy(1);
      if (o_phase_a !== p) n++;
      p = o_phase_a;
    end
    ck(n, 10);
    ck(o_spread_spectrum_modulation, 1);
    wait (o_phase_a !== p);
    cy(2);
    // Counts the cycles with both gates low, from the drop onward
    for (n = 0; !(o_gate_a | o_gate_b) && n < 99; n++) cy(1);
    ck(n, 26);
    ck({o_gate_a, o_gate_b}, {o_phase_a, o_phase_b});
  endtask
  // External clock drives the divider, then stops and must fall back
  task automatic t_ext;
    i_ext_mode = 1;
    run = 1;
    for (n = 0; !o_ext_active && n < 999; n++) cy(1);
    ck(o_ext_active, 1);
    ck(o_spread_spectrum_modulation, 0);
    repeat (4) begin
      @(posedge i_ext_clk);
      p = o_phase_a;
      cy(4);
      ck(o_phase_a, !p);
    end
    // Stop on a rise so the source cannot race into one more pulse
    @(posedge i_ext_clk);
    run = 0;
    for (n = 0; o_ext_active && n < 9999; n++) cy(1);
    ck(n > 1950 && n < 4950, 1);
    i_ext_mode = 0;
  endtask
  // Enable low and supply lockout both release the drains
  task automatic t_off;
    i_enable = 0;
    cy(2);
    ck({o_drain_out_a_oe, o_drain_out_b_oe}, 0);
    i_enable = 1;
    i_supply_lockout = 1;
    cy(2);
    ck({o_drain_out_a_oe, o_drain_out_b_oe}, 0);
    i_supply_lockout = 0;
    cy(200);
    ck({o_drain_out_a_oe, o_drain_out_b_oe}, 3);
  endtask
  // Lasting current limit: off period, then soft start, then run
  task automatic t_oc;
    i_current_limit_state = 1;
    for (n = 0; !o_forced_off_state && n < 99; n++) cy(1);
    ck(n >= 48 && n <= 53, 1);
    i_current_limit_state = 0;
    ck({o_drain_out_a_oe, o_gate_a, o_gate_b}, 0);
    for (n = 0; o_forced_off_state && n < 99; n++) cy(1);
    ck(n >= 48 && n <= 53, 1);
    ck(o_soft_start, 1);
    cy(60);
    ck({o_soft_start, o_drain_out_a_oe}, 1);
  endtask
  initial begin
    // Reset spans three rising edges
    cy(3);
    i_rst = 0;
    cy(1);
    i_enable = 1;
    t_int;
    t_ext;
    t_off;
    t_oc;
    end_of_test;
  end
  // Watchdog well past the expected 25 us of traffic
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule
